// ==== rtl/hwd_pkg.sv ====
// Package with constants of the hardware watchdog
package hwd_pkg;
	localparam int CNT_W = 14;
	localparam logic [CNT_W-1:0] CNT_TERM = 14'h3fff;
	localparam logic [CNT_W-1:0] CNT_RST = 14'h0000;
	localparam logic [7:0] SVC_ADDR = 8'ha6;
	localparam logic [7:0] KEY_FIRST = 8'h1e;
	localparam logic [7:0] KEY_SECOND = 8'he1;
	localparam int MC_DIV_6 = 6;
	localparam int MC_DIV_12 = 12;
	localparam int OSC_PERIOD_NS = 25;
	localparam int CLK_PERIOD_NS = 25;
	localparam int PULSE_OSC_6 = 98;
	localparam int PULSE_OSC_12 = 196;
	localparam int PULSE_CYC_6 = (PULSE_OSC_6 * OSC_PERIOD_NS) / CLK_PERIOD_NS;
	localparam int PULSE_CYC_12 = (PULSE_OSC_12 * OSC_PERIOD_NS) / CLK_PERIOD_NS;
	localparam int PULSE_W = 8;
	localparam logic [PULSE_W-1:0] PULSE_RST = 8'h00;
endpackage : hwd_pkg

// ==== rtl/hwd_mc_if.sv ====
// Interface carrying the machine-cycle tick between divider and watchdog
`timescale 1ns/1ps
interface hwd_mc_if;
	logic mode12;
	logic tick;
	modport src (input mode12, output tick);
	modport snk (output mode12, input tick);
endinterface : hwd_mc_if

// ==== rtl/hwd_mcyc.sv ====
// Machine-cycle divider: one-cycle tick every 6 or 12 oscillator clocks
`timescale 1ns/1ps
module hwd_mcyc (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Tick carrier
	hwd_mc_if.src mc
);
	import hwd_pkg::*;

	typedef struct packed {
		logic [3:0] div;
		logic tick;
	} hwd_mcyc_st_t;

	hwd_mcyc_st_t s_q;
	hwd_mcyc_st_t s_d;
	logic [3:0] last;

	always_comb begin
		s_d = s_q;
		last = mc.mode12 ? 4'(MC_DIV_12 - 1) : 4'(MC_DIV_6 - 1);
		s_d.tick = 1'b0;
		if (s_q.div >= last) begin
			s_d.div = 4'h0;
			s_d.tick = 1'b1;
		end else begin
			s_d.div = s_q.div + 4'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign mc.tick = s_q.tick;
endmodule : hwd_mcyc

// ==== rtl/hwd_top.sv ====
// Hardware watchdog: key-sequence enable and service, overflow reset with reset-pin pulse
`timescale 1ns/1ps
module hwd_top #(
	parameter int COUNT_W = hwd_pkg::CNT_W
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic SYS_RST,
	// Special-function register write port
	input wire logic SFR_WR,
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	// Configuration
	input wire logic CLK12_MODE,
	// Reset pin
	input wire logic RST_PIN_I,
	output logic RST_PIN_O,
	output logic RST_PIN_OE_N,
	// Status and internal reset
	output logic WDT_RST_OUT,
	output logic WDT_ACTIVE
);
	import hwd_pkg::*;

	if (COUNT_W != CNT_W) begin : g_width_check
		$error("COUNT_W must equal the terminal-count width");
	end

	typedef struct packed {
		logic enabled;
		logic armed;
		logic [CNT_W-1:0] cnt;
		logic [PULSE_W-1:0] pulse;
		logic pin;
		logic oe_n;
		logic rst_int;
		logic pin_s1;
		logic pin_s2;
	} hwd_st_t;

	hwd_st_t s_q;
	hwd_st_t s_d;
	logic svc_wr;
	logic key1;
	logic key2;
	logic service;
	logic ovf;
	logic ext_rst;

	hwd_mc_if mc ();

	hwd_mcyc hwd_mcyc_i (
		.clk(CLOCK),
		.rst(SYS_RST),
		.mc(mc.src)
	);

	assign mc.mode12 = CLK12_MODE;

	always_comb begin
		s_d = s_q;
		ext_rst = s_q.pin_s2 & ~s_q.pin;
		svc_wr = SFR_WR & (SFR_ADDR == SVC_ADDR) & ~s_q.pin;
		key1 = svc_wr & (SFR_WDATA == KEY_FIRST);
		key2 = svc_wr & (SFR_WDATA == KEY_SECOND);
		service = key2 & s_q.armed;
		ovf = s_q.enabled & (s_q.cnt == CNT_TERM) & ~service;
		s_d.pin_s1 = RST_PIN_I;
		s_d.pin_s2 = s_q.pin_s1;
		if (svc_wr) begin
			s_d.armed = key1;
		end
		if (service) begin
			s_d.enabled = 1'b1;
			s_d.cnt = CNT_RST;
		end else if (s_q.enabled && mc.tick && !ovf) begin
			s_d.cnt = s_q.cnt + 14'h0001;
		end
		if (s_q.pin) begin
			if (s_q.pulse == PULSE_RST) begin
				s_d.pin = 1'b0;
				s_d.rst_int = 1'b0;
			end else begin
				s_d.pulse = s_q.pulse - 8'h01;
			end
		end
		if (ovf) begin
			s_d.enabled = 1'b0;
			s_d.armed = 1'b0;
			s_d.cnt = CNT_RST;
			s_d.pin = 1'b1;
			s_d.rst_int = 1'b1;
			s_d.pulse = CLK12_MODE ? 8'(PULSE_CYC_12 - 1) : 8'(PULSE_CYC_6 - 1);
		end
		if (ext_rst) begin
			s_d.enabled = 1'b0;
			s_d.armed = 1'b0;
			s_d.cnt = CNT_RST;
		end
		s_d.oe_n = ~s_d.pin;
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s_q <= '{oe_n: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// No read path exists: the service port and counter are invisible
	assign RST_PIN_O = s_q.pin;
	assign RST_PIN_OE_N = s_q.oe_n;
	assign WDT_RST_OUT = s_q.rst_int;
	assign WDT_ACTIVE = s_q.enabled;

	// Helper: length of the current reset-pin pulse
	logic [PULSE_W:0] len_q;
	logic mode_q;
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			len_q <= '0;
			mode_q <= 1'b0;
		end else if (ovf) begin
			len_q <= '0;
			mode_q <= CLK12_MODE;
		end else if (s_q.pin) begin
			len_q <= len_q + 9'h001;
		end
	end

	AST_IDLE_ZERO: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		!s_q.enabled |-> s_q.cnt == CNT_RST)
		else $error("Counter not zero while disabled");
	AST_ENABLE_ORDER: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		$rose(s_q.enabled) |-> $past(s_q.armed) && $past(key2))
		else $error("Enabled without key pair");
	AST_COUNT_STEP: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		s_q.enabled && mc.tick && !svc_wr && !ovf && !ext_rst |=> s_q.cnt == $past(s_q.cnt) + 14'h0001)
		else $error("Counter missed a machine cycle");
	AST_NO_SW_DISABLE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		s_q.enabled && !ovf && !ext_rst |=> s_q.enabled)
		else $error("Watchdog disabled without reset");
	AST_OVF_RESET: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		s_q.enabled && s_q.cnt == CNT_TERM && !service |=> WDT_RST_OUT && RST_PIN_O && !WDT_ACTIVE)
		else $error("Overflow did not reset");
	AST_PIN_DRIVEN: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		RST_PIN_O |-> !RST_PIN_OE_N && WDT_RST_OUT)
		else $error("Reset pin high but not driven");
	AST_OE_TRACK: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		RST_PIN_OE_N == !RST_PIN_O)
		else $error("Output enable does not follow reset pin");
	AST_PULSE_LEN: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		$fell(RST_PIN_O) |-> len_q == (mode_q ? 9'(PULSE_CYC_12) : 9'(PULSE_CYC_6)))
		else $error("Reset pulse length wrong");
	AST_SERVICE_CLEAR: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		s_q.enabled && service && !ext_rst |=> s_q.cnt == CNT_RST ##1 s_q.enabled)
		else $error("Service did not clear counter");
	AST_LONE_KEY: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		!s_q.enabled && !s_q.armed && key2 |=> !s_q.enabled)
		else $error("Second key alone enabled watchdog");

	COV_ENABLE: cover property (@(posedge CLOCK) disable iff (SYS_RST) $rose(s_q.enabled));
	COV_SERVICE: cover property (@(posedge CLOCK) disable iff (SYS_RST) s_q.enabled && service);
	COV_OVERFLOW: cover property (@(posedge CLOCK) disable iff (SYS_RST) $fell(RST_PIN_O));
endmodule : hwd_top

// ==== tb/test_hardware_watchdog_timer.sv ====
// Self-checking bench of the hardware watchdog
`timescale 1ns/1ps
module test_hardware_watchdog_timer;
	import hwd_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic mode12 = 1'b0;
	logic pin_i = 1'b0;
	logic pin_o;
	logic pin_oe_n;
	logic rst_out;
	logic active;
	int n_errors = 0;
	int num_checks = 0;
	hwd_top hwd_top_i (.CLOCK(clk), .SYS_RST(rst), .SFR_WR(wr), .SFR_ADDR(addr), .SFR_WDATA(wdata),
		.CLK12_MODE(mode12), .RST_PIN_I(pin_i), .RST_PIN_O(pin_o), .RST_PIN_OE_N(pin_oe_n),
		.WDT_RST_OUT(rst_out), .WDT_ACTIVE(active));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, got);
		end
	endtask : chk
	task wr_sfr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
		step(1);
	endtask : wr_sfr
	task key(input logic [7:0] a);
		wr_sfr(a, KEY_FIRST);
		wr_sfr(a, KEY_SECOND);
	endtask : key
	task t_reset;
		chk("idle_pin", 32'h0, {pin_o, rst_out, active});
		chk("idle_oe_n", 32'h1, pin_oe_n);
	endtask : t_reset
	task t_broken;
		wr_sfr(SVC_ADDR, KEY_FIRST);
		wr_sfr(SVC_ADDR, 8'h55);
		wr_sfr(SVC_ADDR, KEY_SECOND);
		chk("broken_pair", 32'h0, active);
		key(8'ha5);
		chk("other_addr", 32'h0, active);
	endtask : t_broken
	task t_enable;
		key(SVC_ADDR);
		chk("enabled", 32'h1, active);
		wr_sfr(SVC_ADDR, 8'h00);
		wr_sfr(SVC_ADDR, KEY_SECOND);
		step(20);
		chk("no_sw_disable", 32'h1, active);
	endtask : t_enable
	task t_pin;
		pin_i = 1'b1;
		step(4);
		pin_i = 1'b0;
		step(4);
		chk("pin_reset", 32'h0, active);
		key(SVC_ADDR);
		chk("re_enable", 32'h1, active);
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		step(1);
		chk("sys_reset", 32'h0, active);
		chk("sys_reset_oe_n", 32'h1, pin_oe_n);
	endtask : t_pin
	task t_overflow;
		int n;
		int w;
		int bad;
		key(SVC_ADDR);
		step(600);
		key(SVC_ADDR);
		n = 1;
		while (pin_o !== 1'b1 && n < 99000) begin
			n++;
			step(1);
		end
		chk("ovf_time", 32'h1, (n >= 16383 * 6 - 12) && (n <= 16384 * 6 + 6));
		w = 0;
		bad = 0;
		while (pin_o === 1'b1 && w < 400) begin
			if (pin_oe_n !== 1'b0 || rst_out !== 1'b1 || active !== 1'b0)
				bad++;
			if (w == 10)
				mode12 = 1'b1;
			w++;
			step(1);
		end
		chk("pulse_len", PULSE_CYC_6, w);
		chk("pulse_drive", 32'h0, bad);
		chk("after_oe_n", 32'h1, pin_oe_n);
		chk("after_active", 32'h0, active);
		key(SVC_ADDR);
		chk("mode12_enable", 32'h1, active);
		step(40);
		chk("mode12_active", 32'h1, active);
	endtask : t_overflow
	task results;
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	initial begin
		#(120000 * 25);
		n_errors++;
		results();
	end
	initial begin
		step(8);
		rst = 1'b0;
		step(1);
		t_reset();
		t_broken();
		t_enable();
		t_pin();
		t_overflow();
		results();
	end
endmodule : test_hardware_watchdog_timer
